// File: spm_pkg.sv
// constants shared by the path and far-end line performance counters
// assumes a 20 mhz core clock and a one-second local time base
package spm_pkg;

  // clock and one-second time base
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned ONE_SECOND_NS = 1000000000;
  localparam int unsigned SECOND_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;

  // widths
  localparam int unsigned COUNT_W = 32;
  localparam int unsigned AMT_W = 16;
  localparam int unsigned FRAME_ERR_W = 4;
  localparam int unsigned REI_W = 8;
  localparam int unsigned RUN_W = 4;

  // path limits and thresholds
  localparam logic [FRAME_ERR_W-1:0] PATH_MAX_ERR_PER_FRAME = 4'h8;
  localparam logic [AMT_W-1:0] PATH_SEVERE_THRESHOLD = 16'h0960; // 2400 errors
  localparam logic [RUN_W-1:0] UNAVAIL_RUN_SECONDS = 4'ha;       // ten seconds

  // reset values
  localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [AMT_W-1:0] ACCUM_RESET = 16'h0000;
  localparam logic [RUN_W-1:0] RUN_RESET = 4'h0;

  // unavailability tracker states
  typedef enum logic {SPM_AVAILABLE, SPM_UNAVAILABLE} spm_avail_t;

endpackage

// File: spm_counter.sv
// one saturating performance counter with a wide increment
// assumes increments and clears arrive synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module spm_counter #(
  parameter int unsigned W = spm_pkg::COUNT_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // control
  input wire logic hold_en,
  input wire logic clear,
  input wire logic inc_en,
  input wire logic [spm_pkg::AMT_W-1:0] inc_amt,
  // value
  output logic [W-1:0] count
);

  logic [W-1:0] count_r;
  logic [W:0] sum;

  // one bit of headroom to spot the wrap
  assign sum = {1'b0, count_r} + {{(W + 1 - spm_pkg::AMT_W){1'b0}}, inc_amt};
  assign count = count_r;

  // a clear in the same cycle as an increment keeps the new event
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_r <= spm_pkg::COUNT_RESET[W-1:0];
    end else if (clk_en && hold_en) begin
      if (clear && inc_en) begin
        count_r <= {{(W - spm_pkg::AMT_W){1'b0}}, inc_amt};
      end else if (clear) begin
        count_r <= '0;
      end else if (inc_en) begin
        count_r <= sum[W] ? '1 : sum[W-1:0]; // saturate, never wrap
      end
    end
  end

endmodule
`default_nettype wire

// File: spm_unavail.sv
// unavailable-second tracker fed with one severe/clean verdict per second
// assumes sec_tick is a one-cycle pulse and severe is valid with it
`timescale 1ns/1ps
`default_nettype none
module spm_unavail (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic hold_en,
  // per-second verdict
  input wire logic sec_tick,
  input wire logic severe,
  // result
  output logic unavail,
  output logic uas_inc_en,
  output logic [spm_pkg::AMT_W-1:0] uas_inc_amt
);

  spm_pkg::spm_avail_t state_r;
  logic [spm_pkg::RUN_W-1:0] run_r;
  logic run_done;

  // run counts severe seconds while available, clean ones while not
  assign run_done = (run_r + 4'h1) == spm_pkg::UNAVAIL_RUN_SECONDS;
  assign unavail = (state_r == spm_pkg::SPM_UNAVAILABLE);

  // the ten severe seconds that start an outage are charged at once
  always_comb begin
    uas_inc_en = 1'b0;
    uas_inc_amt = spm_pkg::ACCUM_RESET;
    if (sec_tick) begin
      case (state_r)
        spm_pkg::SPM_AVAILABLE: begin
          if (severe && run_done) begin
            uas_inc_en = 1'b1;
            uas_inc_amt = {12'h000, spm_pkg::UNAVAIL_RUN_SECONDS};
          end
        end
        spm_pkg::SPM_UNAVAILABLE: begin
          uas_inc_en = 1'b1; // clean seconds still count while unavailable
          uas_inc_amt = 16'h0001;
        end
        default: begin
          uas_inc_en = 1'b0;
        end
      endcase
    end
  end

  // state and run length
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= spm_pkg::SPM_AVAILABLE;
      run_r <= spm_pkg::RUN_RESET;
    end else if (clk_en && hold_en && sec_tick) begin
      case (state_r)
        spm_pkg::SPM_AVAILABLE: begin
          if (!severe) begin
            run_r <= spm_pkg::RUN_RESET;
          end else if (run_done) begin
            state_r <= spm_pkg::SPM_UNAVAILABLE;
            run_r <= spm_pkg::RUN_RESET;
          end else begin
            run_r <= run_r + 4'h1;
          end
        end
        spm_pkg::SPM_UNAVAILABLE: begin
          if (severe) begin
            run_r <= spm_pkg::RUN_RESET;
          end else if (run_done) begin
            state_r <= spm_pkg::SPM_AVAILABLE;
            run_r <= spm_pkg::RUN_RESET;
          end else begin
            run_r <= run_r + 4'h1;
          end
        end
        default: begin
          state_r <= spm_pkg::SPM_AVAILABLE;
          run_r <= spm_pkg::RUN_RESET;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// File: spm_pm_counters.sv
// near-end path and far-end line performance counters for one path/line
// assumes overhead processors deliver per-frame errors and defect levels
`timescale 1ns/1ps
`default_nettype none
module spm_pm_counters #(
  parameter int unsigned COUNT_W = spm_pkg::COUNT_W,
  parameter int unsigned SECOND_CYCLES = spm_pkg::SECOND_CYCLES
) (
  // clock, reset and freeze
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // counter management
  input wire logic counters_clear,
  input wire logic intermediate_path_monitor_enable,
  input wire logic [spm_pkg::AMT_W-1:0] far_line_severe_threshold,
  // near-end path events
  input wire logic path_frame_strobe,
  input wire logic [spm_pkg::FRAME_ERR_W-1:0] path_parity_err_count,
  input wire logic path_ais_defect,
  input wire logic path_lop_defect,
  input wire logic path_lower_layer_defect,
  input wire logic path_ais_failure,
  input wire logic path_lop_failure,
  input wire logic path_uneq_failure,
  input wire logic path_tim_failure,
  // far-end line events
  input wire logic line_rei_strobe,
  input wire logic [spm_pkg::REI_W-1:0] line_rei_count,
  input wire logic line_rdi_defect,
  input wire logic line_rfi_failure,
  // status
  output logic second_tick,
  output logic path_unavailable,
  output logic far_line_unavailable,
  output logic far_end_severe_second,
  // near-end path counts
  output logic [COUNT_W-1:0] path_code_violation_count,
  output logic [COUNT_W-1:0] path_errored_second_count,
  output logic [COUNT_W-1:0] path_failure_count,
  output logic [COUNT_W-1:0] path_severe_second_count,
  output logic [COUNT_W-1:0] path_unavailable_second_count,
  // far-end line counts
  output logic [COUNT_W-1:0] far_line_code_violation_count,
  output logic [COUNT_W-1:0] far_line_errored_second_count,
  output logic [COUNT_W-1:0] far_line_severe_second_count,
  output logic [COUNT_W-1:0] far_line_unavailable_second_count,
  output logic [COUNT_W-1:0] far_line_failure_count
);

  localparam logic [31:0] SEC_LAST = 32'(SECOND_CYCLES - 1);

  logic [31:0] sec_cnt_r;
  logic sec_tick;
  logic path_run;
  logic [spm_pkg::FRAME_ERR_W-1:0] frame_err;
  logic path_defect;
  logic path_fail_any;
  logic path_fail_prev_r;
  logic rfi_prev_r;
  logic [spm_pkg::AMT_W-1:0] path_err_acc_r;
  logic [spm_pkg::AMT_W-1:0] path_err_sum;
  logic path_def_acc_r;
  logic [spm_pkg::AMT_W-1:0] far_err_acc_r;
  logic [spm_pkg::AMT_W-1:0] far_err_sum;
  logic far_rdi_acc_r;
  logic path_es;
  logic path_ses;
  logic far_es;
  logic far_ses;
  logic far_ses_r;
  logic path_uas_en;
  logic [spm_pkg::AMT_W-1:0] path_uas_amt;
  logic far_uas_en;
  logic [spm_pkg::AMT_W-1:0] far_uas_amt;

  // local one-second time base, free running while clk_en is high
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sec_cnt_r <= 32'h0000_0000;
    end else if (clk_en) begin
      sec_cnt_r <= (sec_cnt_r >= SEC_LAST) ? 32'h0000_0000 : sec_cnt_r + 32'h0000_0001;
    end
  end

  assign sec_tick = clk_en && (sec_cnt_r >= SEC_LAST);
  assign second_tick = sec_tick;

  // path logic only moves with monitoring enabled
  assign path_run = intermediate_path_monitor_enable;

  // clamp the per-frame parity count, more than eight cannot be real
  assign frame_err = !path_frame_strobe ? 4'h0 :
    (path_parity_err_count > spm_pkg::PATH_MAX_ERR_PER_FRAME) ?
    spm_pkg::PATH_MAX_ERR_PER_FRAME : path_parity_err_count;

  assign path_defect = path_ais_defect || path_lop_defect || path_lower_layer_defect;
  assign path_fail_any = path_ais_failure || path_lop_failure ||
    path_uneq_failure || path_tim_failure;

  // saturating per-second sums so a long burst never reads as a clean second
  assign path_err_sum = (path_err_acc_r > (16'hffff - {12'h000, frame_err})) ? 16'hffff :
    path_err_acc_r + {12'h000, frame_err};
  assign far_err_sum = !line_rei_strobe ? far_err_acc_r :
    (far_err_acc_r > (16'hffff - {8'h00, line_rei_count})) ? 16'hffff :
    far_err_acc_r + {8'h00, line_rei_count};

  // per-second path accumulators; events in the tick cycle open the next second
  always_ff @(posedge core_clk) begin
    if (srst) begin
      path_err_acc_r <= spm_pkg::ACCUM_RESET;
      path_def_acc_r <= 1'b0;
    end else if (clk_en && path_run) begin
      if (sec_tick) begin
        path_err_acc_r <= {12'h000, frame_err};
        path_def_acc_r <= path_defect;
      end else begin
        path_err_acc_r <= path_err_sum;
        path_def_acc_r <= path_def_acc_r || path_defect;
      end
    end
  end

  // per-second far-end accumulators
  always_ff @(posedge core_clk) begin
    if (srst) begin
      far_err_acc_r <= spm_pkg::ACCUM_RESET;
      far_rdi_acc_r <= 1'b0;
    end else if (clk_en) begin
      if (sec_tick) begin
        far_err_acc_r <= line_rei_strobe ? {8'h00, line_rei_count} : spm_pkg::ACCUM_RESET;
        far_rdi_acc_r <= line_rdi_defect;
      end else begin
        far_err_acc_r <= far_err_sum;
        far_rdi_acc_r <= far_rdi_acc_r || line_rdi_defect;
      end
    end
  end

  // second verdicts from the closing second's accumulators
  assign path_es = (path_err_acc_r != spm_pkg::ACCUM_RESET) || path_def_acc_r;
  assign path_ses = (path_err_acc_r >= spm_pkg::PATH_SEVERE_THRESHOLD) || path_def_acc_r;
  assign far_es = (far_err_acc_r != spm_pkg::ACCUM_RESET) || far_rdi_acc_r;
  // a zero threshold would make every second severe; software must load one
  assign far_ses = (far_err_acc_r >= far_line_severe_threshold) || far_rdi_acc_r;

  // remember last far-end verdict for software
  always_ff @(posedge core_clk) begin
    if (srst) begin
      far_ses_r <= 1'b0;
    end else if (clk_en && sec_tick) begin
      far_ses_r <= far_ses;
    end
  end

  assign far_end_severe_second = far_ses_r;

  // failure onset edges; counting at onset charges the starting period
  always_ff @(posedge core_clk) begin
    if (srst) begin
      path_fail_prev_r <= 1'b0;
      rfi_prev_r <= 1'b0;
    end else if (clk_en) begin
      if (path_run) begin
        path_fail_prev_r <= path_fail_any;
      end
      rfi_prev_r <= line_rfi_failure;
    end
  end

  // unavailability trackers
  spm_unavail u_path_uas (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .hold_en(path_run),
    .sec_tick(sec_tick),
    .severe(path_ses),
    .unavail(path_unavailable),
    .uas_inc_en(path_uas_en),
    .uas_inc_amt(path_uas_amt)
  );

  spm_unavail u_far_uas (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .hold_en(1'b1),
    .sec_tick(sec_tick),
    .severe(far_ses),
    .unavail(far_line_unavailable),
    .uas_inc_en(far_uas_en),
    .uas_inc_amt(far_uas_amt)
  );

  // near-end path counters, all held while monitoring is off
  spm_counter #(.W(COUNT_W)) u_path_cv (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .hold_en(path_run),
    .clear(counters_clear),
    .inc_en(path_frame_strobe && frame_err != 4'h0),
    .inc_amt({12'h000, frame_err}),
    .count(path_code_violation_count)
  );

  spm_counter #(.W(COUNT_W)) u_path_es (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .hold_en(path_run),
    .clear(counters_clear),
    .inc_en(sec_tick && path_es),
    .inc_amt(16'h0001),
    .count(path_errored_second_count)
  );

  spm_counter #(.W(COUNT_W)) u_path_fc (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .hold_en(path_run),
    .clear(counters_clear),
    .inc_en(path_fail_any && !path_fail_prev_r),
    .inc_amt(16'h0001),
    .count(path_failure_count)
  );

  spm_counter #(.W(COUNT_W)) u_path_ses (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .hold_en(path_run),
    .clear(counters_clear),
    .inc_en(sec_tick && path_ses),
    .inc_amt(16'h0001),
    .count(path_severe_second_count)
  );

  spm_counter #(.W(COUNT_W)) u_path_uas_cnt (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .hold_en(path_run),
    .clear(counters_clear),
    .inc_en(path_uas_en),
    .inc_amt(path_uas_amt),
    .count(path_unavailable_second_count)
  );

  // far-end line counters; the remote end bounds each report to 255
  spm_counter #(.W(COUNT_W)) u_far_cv (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .hold_en(1'b1),
    .clear(counters_clear),
    .inc_en(line_rei_strobe),
    .inc_amt({8'h00, line_rei_count}),
    .count(far_line_code_violation_count)
  );

  spm_counter #(.W(COUNT_W)) u_far_es (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .hold_en(1'b1),
    .clear(counters_clear),
    .inc_en(sec_tick && far_es),
    .inc_amt(16'h0001),
    .count(far_line_errored_second_count)
  );

  spm_counter #(.W(COUNT_W)) u_far_ses (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .hold_en(1'b1),
    .clear(counters_clear),
    .inc_en(sec_tick && far_ses),
    .inc_amt(16'h0001),
    .count(far_line_severe_second_count)
  );

  spm_counter #(.W(COUNT_W)) u_far_uas_cnt (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .hold_en(1'b1),
    .clear(counters_clear),
    .inc_en(far_uas_en),
    .inc_amt(far_uas_amt),
    .count(far_line_unavailable_second_count)
  );

  // an event still open at a period clear is not counted again
  spm_counter #(.W(COUNT_W)) u_far_fc (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .hold_en(1'b1),
    .clear(counters_clear),
    .inc_en(line_rfi_failure && !rfi_prev_r),
    .inc_amt(16'h0001),
    .count(far_line_failure_count)
  );

endmodule
`default_nettype wire

// File: spm_oh_model.sv
// stand-in for the path and line overhead processors
// assumes the bench sets run and per-frame values at rising core_clk
`timescale 1ns/1ps
`default_nettype none
module spm_oh_model #(
  parameter int unsigned REI_MAX = 255
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // bench control
  input wire logic oh_run,
  input wire logic [3:0] oh_err,
  input wire logic [7:0] oh_rei,
  // toward the counters
  output logic path_frame_strobe,
  output logic [3:0] path_parity_err_count,
  output logic line_rei_strobe,
  output logic [7:0] line_rei_count
);
  // one frame a cycle while running; idle data toggles so stale values never count
  always_ff @(posedge core_clk) begin
    if (srst) begin
      path_frame_strobe <= 1'b0;
      line_rei_strobe <= 1'b0;
      path_parity_err_count <= 4'h0;
      line_rei_count <= 8'h00;
    end else begin
      path_frame_strobe <= oh_run;
      line_rei_strobe <= oh_run;
      path_parity_err_count <= oh_run ? oh_err : ~path_parity_err_count;
      line_rei_count <= !oh_run ? ~line_rei_count : (oh_rei > REI_MAX) ? 8'(REI_MAX) : oh_rei;
    end
  end
endmodule
`default_nettype wire

// File: spm_pm_counters_sva.sv
// port-level assertions for the performance counters
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module spm_pm_counters_sva #(
  parameter int unsigned COUNT_W = 32,
  parameter int unsigned SECOND_CYCLES = 20
) (
  // clock and control
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic counters_clear,
  input wire logic intermediate_path_monitor_enable,
  // events
  input wire logic path_frame_strobe,
  input wire logic [3:0] path_parity_err_count,
  input wire logic path_ais_defect,
  input wire logic path_ais_failure,
  input wire logic path_lop_failure,
  input wire logic path_uneq_failure,
  input wire logic path_tim_failure,
  input wire logic line_rei_strobe,
  input wire logic [7:0] line_rei_count,
  input wire logic line_rdi_defect,
  input wire logic line_rfi_failure,
  // results
  input wire logic second_tick,
  input wire logic path_unavailable,
  input wire logic far_end_severe_second,
  input wire logic [COUNT_W-1:0] path_code_violation_count,
  input wire logic [COUNT_W-1:0] path_failure_count,
  input wire logic [COUNT_W-1:0] path_severe_second_count,
  input wire logic [COUNT_W-1:0] path_unavailable_second_count,
  input wire logic [COUNT_W-1:0] far_line_code_violation_count,
  input wire logic [COUNT_W-1:0] far_line_failure_count
);
  // qualifiers; a clear edge is excluded since set-wins muddles the sums
  wire logic live = !srst && clk_en && !counters_clear;
  wire logic pen = intermediate_path_monitor_enable;
  wire logic pfail = path_ais_failure | path_lop_failure | path_uneq_failure | path_tim_failure;
  wire logic pdef = !srst && clk_en && pen && path_ais_defect;
  wire logic fdef = !srst && clk_en && line_rdi_defect;
  wire logic [3:0] perr = (path_parity_err_count > 4'h8) ? 4'h8 : path_parity_err_count;
  logic [31:0] tcnt_r;

  // independent copy of the second timer
  always_ff @(posedge core_clk) begin
    if (srst) tcnt_r <= 32'h0;
    else if (clk_en) tcnt_r <= (tcnt_r == SECOND_CYCLES - 1) ? 32'h0 : tcnt_r + 32'h1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_path_frozen_off:
  assert property (!srst && !counters_clear && !pen |=> $stable(path_code_violation_count)
    && $stable(path_failure_count) && $stable(path_severe_second_count))
    else $error("path counts moved while monitoring off");
  a_path_cv_adds:
  assert property (live && pen && path_frame_strobe |=> path_code_violation_count ==
    $past(path_code_violation_count) + COUNT_W'($past(perr))) else $error("path cv sum wrong");
  a_far_cv_adds:
  assert property (live && line_rei_strobe |=> far_line_code_violation_count ==
    $past(far_line_code_violation_count) + COUNT_W'($past(line_rei_count)))
    else $error("far cv sum wrong");
  a_tick_period:
  assert property (second_tick == (clk_en && tcnt_r == SECOND_CYCLES - 1))
    else $error("second tick misplaced");
  a_ses_on_defect:
  assert property (live && pen && second_tick && path_ais_defect && $past(pdef) |=>
    path_severe_second_count == $past(path_severe_second_count) + 1)
    else $error("defect second not severe");
  a_far_rdi_severe:
  assert property (live && second_tick && line_rdi_defect && $past(fdef) |=> far_end_severe_second)
    else $error("rdi second not severe");
  a_path_fail_onset:
  assert property (live && pen && $rose(pfail) |=>
    path_failure_count == $past(path_failure_count) + 1) else $error("path failure missed");
  a_far_fail_onset:
  assert property (live && $rose(line_rfi_failure) |=>
    far_line_failure_count == $past(far_line_failure_count) + 1) else $error("rfi event missed");
  a_uas_ten_jump:
  assert property ($rose(path_unavailable) && !$past(counters_clear) |-> $past(second_tick) &&
    path_unavailable_second_count == $past(path_unavailable_second_count) + 10)
    else $error("unavailable entry wrong");
endmodule
`default_nettype wire

// File: spm_pm_counters_tb_top.sv
// self-checking bench for the performance counters
// assumes a 400-cycle second so severe thresholds fit in one second
`timescale 1ns/1ps
`default_nettype none
module spm_pm_counters_tb_top;
  localparam int SEC = 400;
  logic core_clk, srst, clk_en, counters_clear, intermediate_path_monitor_enable, oh_run;
  logic [15:0] far_line_severe_threshold;
  logic path_frame_strobe, line_rei_strobe, line_rdi_defect, line_rfi_failure;
  logic [3:0] path_parity_err_count, oh_err;
  logic [7:0] line_rei_count, oh_rei;
  logic path_ais_defect, path_lop_defect, path_lower_layer_defect;
  logic path_ais_failure, path_lop_failure, path_uneq_failure, path_tim_failure;
  logic second_tick, path_unavailable, far_line_unavailable, far_end_severe_second;
  logic [31:0] path_code_violation_count, path_errored_second_count, path_failure_count;
  logic [31:0] path_severe_second_count, path_unavailable_second_count;
  logic [31:0] far_line_code_violation_count, far_line_errored_second_count;
  logic [31:0] far_line_severe_second_count, far_line_unavailable_second_count;
  logic [31:0] far_line_failure_count;
  int error_cnt = 0;
  int n_checks = 0;

  spm_pm_counters #(.COUNT_W(32), .SECOND_CYCLES(SEC)) i_spm_pm_counters (.*);
  spm_oh_model i_spm_oh_model (.*);

  // 20 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // returns at the edge that closes a second
  task automatic sync();
    do @(negedge core_clk); while (second_tick !== 1'b1);
    @(posedge core_clk);
  endtask

  task automatic clear_now();
    sync();
    counters_clear <= 1'b1;
    @(posedge core_clk);
    counters_clear <= 1'b0;
  endtask

  // n back-to-back frames, then settle at a falling edge
  task automatic burst(input int n, input logic [3:0] e, input logic [7:0] r);
    @(posedge core_clk);
    oh_err <= e;
    oh_rei <= r;
    oh_run <= 1'b1;
    repeat (n) @(posedge core_clk);
    oh_run <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic sc_violations();
    far_line_severe_threshold <= 16'h04fb;
    clear_now();
    intermediate_path_monitor_enable <= 1'b0;
    burst(5, 4'h3, 8'hff);
    @(posedge core_clk);
    intermediate_path_monitor_enable <= 1'b1;
    burst(4, 4'hc, 8'h00);
    chk(path_code_violation_count, 32'h20, "path cv");
    chk(far_line_code_violation_count, 32'h4fb, "far cv");
    sync();
    @(negedge core_clk);
    chk(path_errored_second_count, 32'h1, "path es");
    chk(far_line_errored_second_count, 32'h1, "far es");
    chk(far_line_severe_second_count, 32'h1, "far ses at k");
    chk(far_end_severe_second, 1'b1, "far severe flag");
  endtask

  task automatic sc_severe();
    @(posedge core_clk);
    far_line_severe_threshold <= 16'hffff;
    clear_now();
    burst(300, 4'h8, 8'h00);
    sync();
    @(negedge core_clk);
    chk(path_code_violation_count, 32'h960, "cv 2400");
    chk(path_severe_second_count, 32'h1, "ses at 2400");
    chk(far_end_severe_second, 1'b0, "far not severe");
    burst(299, 4'h8, 8'h00);
    sync();
    @(negedge core_clk);
    chk(path_severe_second_count, 32'h1, "ses below 2400");
    chk(path_errored_second_count, 32'h2, "es count");
  endtask

  task automatic sc_unavail();
    clear_now();
    path_ais_defect <= 1'b1;
    line_rdi_defect <= 1'b1;
    repeat (4) sync();
    // hand over to each other defect kind at a tick edge, the tick cycle seeds the next second
    path_ais_defect <= 1'b0;
    path_lop_defect <= 1'b1;
    repeat (3) sync();
    path_lop_defect <= 1'b0;
    path_lower_layer_defect <= 1'b1;
    repeat (2) sync();
    @(negedge core_clk);
    chk(path_unavailable, 1'b0, "path avail at 9");
    chk(far_line_unavailable, 1'b0, "far avail at 9");
    repeat (5) @(posedge core_clk);
    path_lower_layer_defect <= 1'b0;
    line_rdi_defect <= 1'b0;
    sync();
    @(negedge core_clk);
    chk(path_unavailable_second_count, 32'ha, "uas entry");
    chk(far_line_unavailable_second_count, 32'ha, "far uas entry");
    chk(path_severe_second_count, 32'ha, "ses on ais");
    chk(far_line_errored_second_count, 32'ha, "es on rdi");
    chk(path_errored_second_count, 32'ha, "es on defects");
    repeat (9) sync();
    @(negedge core_clk);
    chk(path_unavailable, 1'b1, "still unavailable");
    sync();
    @(negedge core_clk);
    chk(path_unavailable, 1'b0, "available again");
    chk(path_unavailable_second_count, 32'h14, "uas exit");
    chk(far_line_unavailable_second_count, 32'h14, "far uas exit");
  endtask

  task automatic sc_failures();
    @(posedge core_clk);
    counters_clear <= 1'b1;
    @(posedge core_clk);
    counters_clear <= 1'b0;
    path_ais_failure <= 1'b1;
    repeat (3) @(posedge core_clk);
    path_ais_failure <= 1'b0;
    @(posedge core_clk);
    path_uneq_failure <= 1'b1;
    @(posedge core_clk);
    path_tim_failure <= 1'b1;
    @(posedge core_clk);
    path_uneq_failure <= 1'b0;
    @(posedge core_clk);
    path_tim_failure <= 1'b0;
    intermediate_path_monitor_enable <= 1'b0;
    @(posedge core_clk);
    path_lop_failure <= 1'b1;
    @(posedge core_clk);
    path_lop_failure <= 1'b0;
    line_rfi_failure <= 1'b1;
    @(posedge core_clk);
    intermediate_path_monitor_enable <= 1'b1;
    line_rfi_failure <= 1'b0;
    @(posedge core_clk);
    line_rfi_failure <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(path_failure_count, 32'h2, "path fc");
    chk(far_line_failure_count, 32'h2, "far fc");
    @(posedge core_clk);
    counters_clear <= 1'b1;
    @(posedge core_clk);
    counters_clear <= 1'b0;
    repeat (3) @(posedge core_clk);
    line_rfi_failure <= 1'b0;
    @(negedge core_clk);
    chk(far_line_failure_count, 32'h0, "open event");
  endtask

  // clk_en low drops frames and holds the second timer
  task automatic sc_freeze();
    int n;
    clear_now();
    clk_en <= 1'b0;
    burst(6, 4'h2, 8'h07);
    chk(path_code_violation_count, 32'h0, "frozen cv");
    chk(far_line_code_violation_count, 32'h0, "frozen far cv");
    @(posedge core_clk);
    clk_en <= 1'b1;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (second_tick !== 1'b1);
    chk(n, SEC - 1, "tick held by clk_en");
  endtask

  // reset, then the scenarios in turn
  initial begin
    srst = 1'b1;
    clk_en = 1'b1;
    counters_clear = 1'b0;
    intermediate_path_monitor_enable = 1'b1;
    far_line_severe_threshold = 16'hffff;
    {oh_run, oh_err, oh_rei} = '0;
    {path_ais_defect, path_lop_defect, path_lower_layer_defect, line_rdi_defect} = '0;
    {path_ais_failure, path_lop_failure, path_uneq_failure, path_tim_failure} = '0;
    line_rfi_failure = 1'b0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    sc_violations();
    sc_severe();
    sc_unavail();
    sc_freeze();
    sc_failures();
    tally_and_finish();
  end

  // about 30 seconds of traffic; well past that means a hang
  initial begin
    repeat (40 * SEC) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
bind spm_pm_counters spm_pm_counters_sva #(.COUNT_W(COUNT_W), .SECOND_CYCLES(SECOND_CYCLES))
  i_spm_pm_counters_sva (.*);
`default_nettype wire
